// File: hw/cmb_mailbox_top.sv
// Mailbox command handling: APB registers, per-mailbox state, transmit sequencing.
// Assumes a protocol engine on pclk that takes tx_req and reports start, done,
// loss and received frames; its signals need no synchroniser.
//
// Summary of operation
// - Length code is the sent length for transmit and producer, ignored otherwise.
// - Transmit mailbox sends RTR when remote-request written one; no effect elsewhere.
// - Consumer mailbox always sends its frame with RTR set.
// - One consumer mailbox sends the remote frame then takes the answer.
// - Transmit abort cancels request before handover; receive aborts do nothing.
// - Consumer abort cancels the transfer before the remote frame is sent.
// - Producer abort cancels transfer and ignores the next remote frame.
// - Group abort register aborts several mailboxes in one write.
// - Transfer command enables next reception, or restarts overwrite reception.
// - Transmit transfer command sends the prepared data as soon as possible.
// - Consumer transfer command sends a remote frame.
// - Producer transfer command arms it to answer a received remote frame.
// - Transfer command clears the mailbox ready and aborted flags.
// - Simultaneous transmit requests are served in turn, highest priority first.
// - Equal priority goes to the lowest mailbox index.
// - Group transfer register commands several mailboxes in one write.
// - Transmit mailbox sets ready once its data went out.
// - Consumer mailbox sets ready once a message arrived after its remote frame went out.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"

module cmb_mailbox_top #(
  parameter int N = 8
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       tx_req,
  output logic [$clog2(N)-1:0]       tx_mailbox,
  output cmb_pkg::cmb_dlc_type       tx_length,
  output logic                       tx_remote,
  input  wire logic                  tx_start,
  input  wire logic                  tx_done,
  input  wire logic                  tx_fail,
  input  wire logic                  rx_valid,
  input  wire logic [$clog2(N)-1:0]  rx_mailbox,
  input  wire logic                  rx_remote,
  output logic [N-1:0]               mailbox_ready_flag
);
  import cmb_pkg::*;

  localparam int IW = $clog2(N);

  // ****************************************
  // APB slave
  // ****************************************
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        access;
  logic        wr_commit;

  // One wait state: pready rises on the second access cycle
  assign access    = psel & penable;
  assign wr_commit = access & pready_reg & pwrite;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a < `CMB_GXFER + 8'h04);
  endfunction

  cmb_otype_type mode_type [N];
  cmb_prio_type  mode_prio [N];
  logic [N-1:0]  pending_reg;
  logic [N-1:0]  ready_reg;
  logic [N-1:0]  aborted_reg;
  cmb_dlc_type   dlc_reg   [N];

  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = '0;
    for (int i = 0; i < N; i++) begin
      if (a == `CMB_MODE_BASE + 8'(4 * i)) begin
        read_word[`CMB_TYPE_LSB +: 3] = mode_type[i];
        read_word[`CMB_PRIO_LSB +: 4] = mode_prio[i];
      end
      if (a == `CMB_STAT_BASE + 8'(4 * i)) begin
        read_word[`CMB_DLC_LSB +: 4]  = dlc_reg[i];
        read_word[`CMB_ABORTED_BIT]   = aborted_reg[i];
        read_word[`CMB_READY_BIT]     = ready_reg[i];
        read_word[`CMB_PEND_BIT]      = pending_reg[i];
      end
    end
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access & ~pready_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (access & ~pready_reg) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : read_word(paddr);
      pslverr_reg <= ~addr_mapped(paddr);
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // Command decode and arbitration
  // ****************************************
  cmb_cmd_if #(.N(N)) cmd ();
  cmb_arb_if #(.N(N)) arb ();

  cmb_cmd_decode #(.N(N)) u_decode (
    .wr_commit (wr_commit),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .cmd       (cmd)
  );

  cmb_tx_arbiter #(.N(N)) u_arbiter (
    .arb (arb)
  );

  // ****************************************
  // Transmit sequencer
  // ****************************************
  cmb_seq_state_type seq_reg;
  logic [IW-1:0]     cur_reg;
  logic              tx_req_reg;
  cmb_dlc_type       tx_length_reg;
  logic              tx_remote_reg;
  logic              rtr_reg [N];

  assign arb.req = pending_reg;

  // A newer, more urgent request waits until the current one ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg       <= SEQ_IDLE;
      cur_reg       <= '0;
      tx_req_reg    <= 1'b0;
      tx_length_reg <= 4'h0;
      tx_remote_reg <= 1'b0;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          if (arb.grant_valid) begin
            seq_reg       <= SEQ_REQ;
            cur_reg       <= arb.grant_idx;
            tx_req_reg    <= 1'b1;
            tx_length_reg <= dlc_reg[arb.grant_idx];
            tx_remote_reg <= rtr_reg[arb.grant_idx];
          end
        end
        SEQ_REQ: begin
          if (tx_start) begin
            seq_reg    <= SEQ_SEND;
            tx_req_reg <= 1'b0;
          end else if (!pending_reg[cur_reg]) begin
            seq_reg    <= SEQ_IDLE;
            tx_req_reg <= 1'b0;
          end
        end
        SEQ_SEND: begin
          // A lost frame stays pending and is arbitrated again
          if (tx_done || tx_fail) begin
            seq_reg <= SEQ_IDLE;
          end
        end
        default: begin
          seq_reg    <= SEQ_IDLE;
          tx_req_reg <= 1'b0;
        end
      endcase
    end
  end

  assign tx_req     = tx_req_reg;
  assign tx_mailbox = cur_reg;
  assign tx_length  = tx_length_reg;
  assign tx_remote  = tx_remote_reg;

  // ****************************************
  // Per-mailbox state
  // ****************************************
  logic [N-1:0] armed_reg;
  logic [N-1:0] skip_reg;
  logic [N-1:0] rx_en_reg;

  for (genvar g = 0; g < N; g++) begin : g_mbx
    logic     on_wire;
    logic     sent;
    logic     rx_data;
    logic     rx_rtr;
    logic     is_tx;
    logic     is_cons;
    logic     is_prod;
    logic     is_rx;
    logic     abort_ok;
    logic     set_ready;
    logic     set_abt;
    logic     serve;

    assign is_tx    = mode_type[g] == `CMB_OT_TX;
    assign is_cons  = mode_type[g] == `CMB_OT_CONS;
    assign is_prod  = mode_type[g] == `CMB_OT_PROD;
    assign is_rx    = mode_type[g] == `CMB_OT_RX || mode_type[g] == `CMB_OT_RXOVR;
    // Once the engine has taken the frame an abort cannot recall it
    assign on_wire  = cur_reg == IW'(g)
                      && (seq_reg == SEQ_SEND || (seq_reg == SEQ_REQ && tx_start));
    assign sent     = seq_reg == SEQ_SEND && tx_done && cur_reg == IW'(g);
    assign rx_data  = rx_valid && !rx_remote && rx_mailbox == IW'(g);
    assign rx_rtr   = rx_valid && rx_remote && rx_mailbox == IW'(g);
    assign abort_ok = cmd.abort[g] && !on_wire && pending_reg[g]
                      && (is_tx || is_cons);
    assign serve    = rx_rtr && is_prod && armed_reg[g] && !skip_reg[g];
    assign set_ready = (rx_data && rx_en_reg[g] && (is_rx || is_cons))
                       || (sent && (is_tx || is_prod));
    assign set_abt  = abort_ok || (cmd.abort[g] && is_prod);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode_type[g] <= 3'(`CMB_MODE_RESET);
        mode_prio[g] <= 4'h0;
      end else if (wr_commit && paddr == `CMB_MODE_BASE + 8'(4 * g)) begin
        mode_type[g] <= pwdata[`CMB_TYPE_LSB +: 3];
        mode_prio[g] <= pwdata[`CMB_PRIO_LSB +: 4];
      end
    end
    assign arb.prio[g] = mode_prio[g];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dlc_reg[g] <= 4'h0;
        rtr_reg[g] <= 1'b0;
      end else if (cmd.xfer[g]) begin
        // A group transfer carries no length or remote field: keep the prepared ones
        if (is_tx && paddr != `CMB_GXFER) begin
          dlc_reg[g] <= cmd.dlc;
          rtr_reg[g] <= cmd.rtr;
        end else if (is_prod && paddr != `CMB_GXFER) begin
          dlc_reg[g] <= cmd.dlc;
          rtr_reg[g] <= 1'b0;
        end else if (is_cons) begin
          rtr_reg[g] <= 1'b1;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pending_reg[g] <= 1'b0;
      end else if (cmd.xfer[g] && (is_tx || is_cons)) begin
        pending_reg[g] <= 1'b1;
      end else if (abort_ok || (cmd.abort[g] && is_prod && !on_wire)) begin
        pending_reg[g] <= 1'b0;
      end else if (sent) begin
        pending_reg[g] <= 1'b0;
      end else if (serve) begin
        pending_reg[g] <= 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        armed_reg[g] <= 1'b0;
        skip_reg[g]  <= 1'b0;
      end else if (cmd.xfer[g] && is_prod) begin
        armed_reg[g] <= 1'b1;
        skip_reg[g]  <= 1'b0;
      end else if (cmd.abort[g] && is_prod) begin
        armed_reg[g] <= 1'b0;
        skip_reg[g]  <= 1'b1;
      end else if (rx_rtr && is_prod) begin
        armed_reg[g] <= 1'b0;
        skip_reg[g]  <= 1'b0;
      end
    end

    // Overwrite mode stays open; plain receive and consumer take one message
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_en_reg[g] <= 1'b0;
      end else if (cmd.xfer[g]) begin
        rx_en_reg[g] <= is_rx;
      end else if (sent && is_cons) begin
        rx_en_reg[g] <= 1'b1;
      end else if (rx_data && mode_type[g] != `CMB_OT_RXOVR) begin
        rx_en_reg[g] <= 1'b0;
      end
    end

    // Hardware set wins over the command clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ready_reg[g]   <= 1'b0;
        aborted_reg[g] <= 1'b0;
      end else begin
        if (set_ready) begin
          ready_reg[g] <= 1'b1;
        end else if (cmd.xfer[g]) begin
          ready_reg[g] <= 1'b0;
        end
        if (set_abt) begin
          aborted_reg[g] <= 1'b1;
        end else if (cmd.xfer[g]) begin
          aborted_reg[g] <= 1'b0;
        end
      end
    end
  end

  assign mailbox_ready_flag = ready_reg;

endmodule

`default_nettype wire

// File: include/cmb_defs.svh
// Register map, field positions and object type codes of the mailbox command block.
// Assumes byte addresses on an 8-bit APB address and 32-bit data.
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH

// ****************************************
// Register offsets (three words per mailbox: mode, control and status; plus the group abort and group transfer words)
// ****************************************
`define CMB_MODE_BASE   8'h00
`define CMB_CTRL_BASE   8'h20
`define CMB_STAT_BASE   8'h40
`define CMB_GABORT      8'h60
`define CMB_GXFER       8'h64

// ****************************************
// Field positions
// ****************************************
`define CMB_DLC_LSB     16
`define CMB_RTR_BIT     20
`define CMB_ABORT_BIT   22
`define CMB_XFER_BIT    23
`define CMB_ABORTED_BIT 22
`define CMB_READY_BIT   23
`define CMB_PEND_BIT    24
`define CMB_TYPE_LSB    0
`define CMB_PRIO_LSB    16

// ****************************************
// Object types and reset values
// ****************************************
`define CMB_OT_OFF      3'h0
`define CMB_OT_RX       3'h1
`define CMB_OT_RXOVR    3'h2
`define CMB_OT_TX       3'h3
`define CMB_OT_CONS     3'h4
`define CMB_OT_PROD     3'h5
`define CMB_MODE_RESET  32'h0000_0000

`endif

// File: include/cmb_pkg.sv
// Types shared by the mailbox command block modules.
// Assumes nothing beyond a SystemVerilog compiler.
package cmb_pkg;
  typedef logic [3:0] cmb_dlc_type;
  typedef logic [3:0] cmb_prio_type;
  typedef logic [2:0] cmb_otype_type;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_REQ,
    SEQ_SEND
  } cmb_seq_state_type;
endpackage

// File: include/cmb_links_if.sv
// Interfaces between the mailbox top, its command decoder and its arbiter.
// Assumes all three run on the same clock.
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Decoded one-shot commands
// ****************************************
interface cmb_cmd_if #(parameter int N = 8);
  logic [N-1:0]        xfer;
  logic [N-1:0]        abort;
  cmb_pkg::cmb_dlc_type dlc;
  logic                rtr;
  modport drv (output xfer, output abort, output dlc, output rtr);
  modport mbx (input xfer, input abort, input dlc, input rtr);
endinterface

// ****************************************
// Transmit arbitration
// ****************************************
interface cmb_arb_if #(parameter int N = 8);
  logic [N-1:0]         req;
  cmb_pkg::cmb_prio_type prio [N];
  logic                 grant_valid;
  logic [$clog2(N)-1:0] grant_idx;
  modport arb (input req, input prio, output grant_valid, output grant_idx);
  modport mbx (output req, output prio, input grant_valid, input grant_idx);
endinterface

`default_nettype wire

// File: hw/cmb_cmd_decode.sv
// Turns a committed APB write into one-shot transfer and abort commands.
// Assumes the write strobe is high for exactly the committing cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"

module cmb_cmd_decode #(
  parameter int N = 8
) (
  input  wire logic        wr_commit,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  cmb_cmd_if.drv           cmd
);
  import cmb_pkg::*;

  always_comb begin
    cmd.xfer  = '0;
    cmd.abort = '0;
    cmd.dlc   = pwdata[`CMB_DLC_LSB +: 4];
    cmd.rtr   = pwdata[`CMB_RTR_BIT];
    if (wr_commit) begin
      for (int i = 0; i < N; i++) begin
        // Zero bits are no-ops, nothing is stored here
        if (paddr == `CMB_CTRL_BASE + 8'(4 * i)) begin
          cmd.xfer[i]  = pwdata[`CMB_XFER_BIT];
          cmd.abort[i] = pwdata[`CMB_ABORT_BIT];
        end
      end
      if (paddr == `CMB_GABORT) begin
        cmd.abort = pwdata[N-1:0];
      end
      if (paddr == `CMB_GXFER) begin
        cmd.xfer = pwdata[N-1:0];
      end
    end
  end
endmodule

`default_nettype wire

// File: hw/cmb_tx_arbiter.sv
// Picks the pending mailbox with the best priority, lowest index on a tie.
// Assumes a smaller priority value means a more urgent mailbox.
`timescale 1ns/100ps
`default_nettype none

module cmb_tx_arbiter #(
  parameter int N = 8
) (
  cmb_arb_if.arb arb
);
  import cmb_pkg::*;

  always_comb begin
    cmb_prio_type best;
    best            = '1;
    arb.grant_valid = 1'b0;
    arb.grant_idx   = '0;
    // Ascending scan with strict compare keeps the lowest index on ties
    for (int i = 0; i < N; i++) begin
      if (arb.req[i] && (!arb.grant_valid || arb.prio[i] < best)) begin
        arb.grant_valid = 1'b1;
        arb.grant_idx   = ($clog2(N))'(i);
        best            = arb.prio[i];
      end
    end
  end
endmodule

`default_nettype wire

// File: dv/cmb_mailbox_chk.sv
// Port assertions for the mailbox command block.
// Assumes a bind into cmb_mailbox_top; mailbox types are tracked from mode writes.
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"
module cmb_mailbox_chk #(
  parameter int N = 8
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 tx_req,
  input wire logic [$clog2(N)-1:0] tx_mailbox,
  input wire logic                 tx_remote,
  input wire logic                 tx_start,
  input wire logic                 tx_done,
  input wire logic                 rx_valid,
  input wire logic [N-1:0]         mailbox_ready_flag
);
  import cmb_pkg::*;
  cmb_otype_type typ_reg [N];
  logic [N-1:0]  rtr_reg;
  logic [2:0]    cidx_reg;
  logic          ctrl_wr;
  logic          commit;
  assign commit  = psel && penable && pready && pwrite && !pslverr;
  assign ctrl_wr = commit && paddr[7:5] == 3'h1;
  // ****************************************
  // Software view of each mailbox
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        typ_reg[i] <= `CMB_OT_OFF;
      end
      rtr_reg <= '0;
    end else if (commit && paddr[7:5] == 3'h0) begin
      typ_reg[paddr[4:2]] <= pwdata[2:0];
    end else if (ctrl_wr && pwdata[`CMB_XFER_BIT]) begin
      rtr_reg[paddr[4:2]] <= pwdata[20];
    end
  end
  // Index of the last write, so a flag can be judged one edge later
  always_ff @(posedge pclk) begin
    cidx_reg <= paddr[4:2];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  chk_apb_wait: assert property (s_setup |=> s_one_wait)
    else $error("apb answer not after one wait state");
  chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  chk_remote_bit: assert property (
    tx_req |-> tx_remote == (typ_reg[tx_mailbox] == `CMB_OT_CONS ||
      (typ_reg[tx_mailbox] == `CMB_OT_TX && rtr_reg[tx_mailbox])))
    else $error("wrong remote bit on offered frame");
  chk_rx_silent: assert property (
    tx_req |-> typ_reg[tx_mailbox] inside {`CMB_OT_TX, `CMB_OT_CONS, `CMB_OT_PROD})
    else $error("receive or idle mailbox offered");
  chk_abort_drop: assert property (
    ctrl_wr && pwdata[22] && !pwdata[23] && tx_req && !tx_start &&
    tx_mailbox == paddr[4:2] |-> ##[1:2] !tx_req)
    else $error("aborted offer not withdrawn");
  chk_tx_ready: assert property (
    tx_done && typ_reg[tx_mailbox] == `CMB_OT_TX |=> mailbox_ready_flag[tx_mailbox])
    else $error("ready not set after transmit");
  chk_xfer_clear: assert property (
    ctrl_wr && pwdata[23] && !tx_done && !rx_valid |=> !mailbox_ready_flag[cidx_reg])
    else $error("ready not cleared by transfer");
  chk_req_hold: assert property (
    tx_req && !tx_start |=> $stable(tx_mailbox))
    else $error("offered mailbox changed");
endmodule
bind cmb_mailbox_top cmb_mailbox_chk #(.N(N)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_req(tx_req), .tx_mailbox(tx_mailbox), .tx_remote(tx_remote), .tx_start(tx_start),
  .tx_done(tx_done), .rx_valid(rx_valid), .mailbox_ready_flag(mailbox_ready_flag)
);
`default_nettype wire

// File: dv/cmb_engine_model.sv
// Behavioural CAN protocol engine taking the block's frame offers.
// Assumes pclk only; stall holds offers back, fail_one loses each frame.
`timescale 1ns/100ps
`default_nettype none
module cmb_engine_model (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 tx_req,
  input  wire logic [2:0]           tx_mailbox,
  input  wire cmb_pkg::cmb_dlc_type tx_length,
  input  wire logic                 tx_remote,
  input  wire logic                 stall,
  input  wire logic                 fail_one,
  output logic                      tx_start,
  output logic                      tx_done,
  output logic                      tx_fail
);
  import cmb_pkg::*;
  logic [7:0] log_q [$];
  logic       busy;
  logic [1:0] cnt;
  initial {tx_start, tx_done, tx_fail, busy} = 4'h0;
  // ****************************************
  // Frame on the wire: start, a few cycles, then done or lost
  // ****************************************
  always @(posedge pclk) begin
    tx_start <= 1'b0;
    tx_done <= 1'b0;
    tx_fail <= 1'b0;
    if (!presetn) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt + 2'd1;
      if (cnt == 2'd3) begin
        busy <= 1'b0;
        tx_fail <= fail_one;
        tx_done <= !fail_one;
      end
    end else if (tx_req && !stall) begin
      tx_start <= 1'b1;
      busy <= 1'b1;
      cnt <= 2'd0;
      log_q.push_back({tx_remote, tx_length, tx_mailbox});
    end
  end
endmodule
`default_nettype wire

// File: dv/cmb_mailbox_command_logic_test.sv
// Self-checking bench for the mailbox command block.
// Assumes the engine model logs every frame as {remote, length, mailbox}.
`timescale 1ns/100ps
`default_nettype none
`include "cmb_defs.svh"
module cmb_mailbox_command_logic_test;
  logic pclk, presetn, psel, penable, pwrite, rx_valid, rx_remote, stall, fail_one;
  logic tx_req, tx_remote, tx_start, tx_done, tx_fail, pready, pslverr, err;
  logic [7:0]           paddr, mailbox_ready_flag;
  logic [31:0]          pwdata, prdata, rd;
  logic [2:0]           tx_mailbox, rx_mailbox;
  cmb_pkg::cmb_dlc_type tx_length;
  int                   n_errors = 0, cmp_count = 0, cyc = 0;
  cmb_mailbox_top #(.N(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_req(tx_req), .tx_mailbox(tx_mailbox), .tx_length(tx_length), .tx_remote(tx_remote),
    .tx_start(tx_start), .tx_done(tx_done), .tx_fail(tx_fail), .rx_valid(rx_valid),
    .rx_mailbox(rx_mailbox), .rx_remote(rx_remote), .mailbox_ready_flag(mailbox_ready_flag)
  );
  cmb_engine_model eng (
    .pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_mailbox(tx_mailbox),
    .tx_length(tx_length), .tx_remote(tx_remote), .stall(stall), .fail_one(fail_one),
    .tx_start(tx_start), .tx_done(tx_done), .tx_fail(tx_fail)
  );
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic finish_test;
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rds(input int mb, input logic [2:0] exp);
    apb(1'b0, `CMB_STAT_BASE + 8'(4 * mb), 32'h0);
    check(32'(rd[24:22]), 32'(exp));
  endtask
  task automatic rx(input logic [2:0] mb, input logic rem);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_mailbox <= mb;
    rx_remote <= rem;
    @(posedge pclk);
    rx_valid <= 1'b0;
  endtask
  task automatic wait_log(input int n);
    int t;
    t = 0;
    @(negedge pclk);
    while (eng.log_q.size() < n && t++ < 200) @(negedge pclk);
    check(32'(eng.log_q.size()), 32'(n));
    @(posedge pclk);
  endtask
  task automatic wait_flag(input int mb, input logic exp);
    int t;
    t = 0;
    @(negedge pclk);
    while (mailbox_ready_flag[mb] !== exp && t++ < 40) @(negedge pclk);
    check(32'(mailbox_ready_flag[mb]), 32'(exp));
    @(posedge pclk);
  endtask
  // Absence of a frame can only be judged after a quiet stretch
  task automatic quiet(input int n);
    repeat (12) @(posedge pclk);
    check(32'(eng.log_q.size()), 32'(n));
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    apb(1'b0, `CMB_MODE_BASE, 32'h0);
    check(rd, 32'h0);
    wr(`CMB_MODE_BASE + 8'h1c, 32'h0003_0005);
    apb(1'b0, `CMB_MODE_BASE + 8'h1c, 32'h0);
    check(rd, 32'h0003_0005);
    apb(1'b0, `CMB_CTRL_BASE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    check(32'(err), 32'h1);
    wr(8'h41, 32'h0);
    check(32'(err), 32'h1);
    wr(`CMB_MODE_BASE + 8'h1c, 32'h0);
  endtask
  task automatic t_tx;
    wr(`CMB_MODE_BASE, 32'h0000_0003);
    fail_one <= 1'b1;
    wr(`CMB_CTRL_BASE, 32'h0095_0000);
    wait_log(1);
    // The engine decides the loss at the end of the frame, so keep failing until then
    @(posedge pclk iff tx_fail === 1'b1);
    fail_one <= 1'b0;
    wait_log(2);
    check(32'(eng.log_q[0]), 32'h0000_00a8);
    check(32'(eng.log_q[1]), 32'h0000_00a8);
    wait_flag(0, 1'b1);
    stall <= 1'b1;
    wr(`CMB_CTRL_BASE, 32'h0015_0000);
    rds(0, 3'b010);
    wr(`CMB_CTRL_BASE, 32'h0095_0000);
    rds(0, 3'b100);
    wr(`CMB_CTRL_BASE, 32'h0055_0000);
    rds(0, 3'b001);
    stall <= 1'b0;
    quiet(2);
  endtask
  task automatic t_arb;
    stall <= 1'b1;
    wr(`CMB_MODE_BASE + 8'h04, 32'h0002_0003);
    wr(`CMB_MODE_BASE + 8'h08, 32'h0001_0003);
    wr(`CMB_MODE_BASE + 8'h0c, 32'h0001_0003);
    wr(`CMB_GXFER, 32'h0000_000e);
    stall <= 1'b0;
    wait_log(5);
    check(32'(eng.log_q[2]), 32'h0000_0002);
    check(32'(eng.log_q[3]), 32'h0000_0003);
    check(32'(eng.log_q[4]), 32'h0000_0001);
  endtask
  task automatic t_cons;
    wr(`CMB_MODE_BASE + 8'h10, 32'h0000_0004);
    wr(`CMB_CTRL_BASE + 8'h10, 32'h0080_0000);
    wait_log(6);
    check(32'(eng.log_q[5]), 32'h0000_0084);
    repeat (8) @(posedge pclk);
    wait_flag(4, 1'b0);
    rx(3'h4, 1'b0);
    wait_flag(4, 1'b1);
  endtask
  task automatic t_prod;
    wr(`CMB_MODE_BASE + 8'h14, 32'h0000_0005);
    wr(`CMB_CTRL_BASE + 8'h14, 32'h0083_0000);
    quiet(6);
    rx(3'h5, 1'b1);
    wait_log(7);
    check(32'(eng.log_q[6]), 32'h0000_001d);
    repeat (8) @(posedge pclk);
    wr(`CMB_CTRL_BASE + 8'h14, 32'h0083_0000);
    wr(`CMB_GABORT, 32'h0000_0020);
    rds(5, 3'b001);
    rx(3'h5, 1'b1);
    quiet(7);
  endtask
  task automatic t_rx;
    wr(`CMB_MODE_BASE + 8'h18, 32'h0000_0001);
    wr(`CMB_CTRL_BASE + 8'h18, 32'h0090_0000);
    rx(3'h6, 1'b0);
    wait_flag(6, 1'b1);
    wr(`CMB_CTRL_BASE + 8'h18, 32'h0040_0000);
    apb(1'b0, `CMB_STAT_BASE + 8'h18, 32'h0);
    check(32'(rd[23:22]), 32'h2);
    quiet(7);
    wr(`CMB_MODE_BASE + 8'h1c, 32'h0000_0002);
    wr(`CMB_CTRL_BASE + 8'h1c, 32'h0080_0000);
    rx(3'h7, 1'b0);
    wait_flag(7, 1'b1);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, rx_valid, rx_remote, stall, fail_one} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rx_mailbox = 3'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_tx;
    t_arb;
    t_cons;
    t_prod;
    t_rx;
    finish_test;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      $display("MISMATCH %0t timeout", $time);
      n_errors++;
      finish_test;
    end
  end
endmodule
`default_nettype wire
